// File: design/hsc_consts.svh
// hsc_consts.svh: named constants of the chirp handshake, both ends
// assumes: included by bare name; definitions only
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

// line condition encodings {dm, dp}
`define HSC_LINE_SE0 2'h0
`define HSC_LINE_J 2'h1
`define HSC_LINE_K 2'h2
`define HSC_LINE_SE1 2'h3

// operational select modes
`define HSC_OPSEL_NORMAL 2'h0
`define HSC_OPSEL_NON_DRIVING 2'h1
`define HSC_OPSEL_RAW 2'h2

// speed and termination selects
`define HSC_SPEED_FS 1'h0
`define HSC_SPEED_HS 1'h1
`define HSC_TERM_HS 1'h0
`define HSC_TERM_FS 1'h1

// timing in output-clock cycles
`define HSC_CHIRP_CYC 66000
`define HSC_FILT_CYC 165
`define HSC_CHIRP_PAIRS 6
// no-chirp timeout: 2.0 ms at 60 MHz nominal output clock
`define HSC_FS_TIMEOUT_US 2000
`define HSC_OUTCLK_MHZ 60
`define HSC_FS_TIMEOUT_CYC (`HSC_FS_TIMEOUT_US * `HSC_OUTCLK_MHZ)

// wake time of the output clock after leaving low power, at 40 MHz
`define HSC_SYS_MHZ 40
`define HSC_WAKE_US 5600
`define HSC_WAKE_CYC (`HSC_WAKE_US * `HSC_SYS_MHZ)

`define HSC_TX_ZERO 8'h00

`endif

// File: design/hsc_pkg.sv
// hsc_pkg: types shared by both ends of the chirp handshake
// assumes: hsc_consts.svh holds the numbers
package hsc_pkg;
    // gray codes along idle, chirp, listen, hs
    typedef enum logic [2:0] {
        HSC_ST_IDLE = 3'h0,
        HSC_ST_CHIRP = 3'h1,
        HSC_ST_LISTEN = 3'h3,
        HSC_ST_HS = 3'h2,
        HSC_ST_FS = 3'h6,
        HSC_ST_SUSP = 3'h7,
        HSC_ST_WAKE = 3'h5
    } hsc_state_t;
endpackage

// File: design/hsc_if.sv
// hsc_if: parallel control interface between transceiver and link
// assumes: both ends on sys_clk; phy_clk_en stands for the output clock
`timescale 1ns/100ps
`default_nettype none
interface hsc_if;
    logic [1:0] bus_line_condition;
    logic phy_clk_en;
    logic low_power_request_n;
    logic [1:0] operational_select;
    logic speed_select;
    logic termination_select;
    logic [7:0] tx_data;
    logic tx_valid;

    modport link (
        input bus_line_condition, phy_clk_en,
        output low_power_request_n, operational_select, speed_select,
        output termination_select, tx_data, tx_valid
    );
    modport phy (
        output bus_line_condition, phy_clk_en,
        input low_power_request_n, operational_select, speed_select,
        input termination_select, tx_data, tx_valid
    );
endinterface
`default_nettype wire

// File: design/hsc_phy_end.sv
// hsc_phy_end: transceiver end; line condition, output clock enable,
// termination and chirp drive controls
// assumes: dp/dm come from pins; analog drivers sit outside
`timescale 1ns/100ps
`default_nettype none
`include "hsc_consts.svh"
module hsc_phy_end
    import hsc_pkg::*;
#(
    parameter int WAKE_CYC = `HSC_WAKE_CYC,
    parameter int CLK_DIV = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // link side
    hsc_if.phy lnk,
    // bus pins
    input wire logic dp_in,
    input wire logic dm_in,
    // analog controls
    output logic dp_pullup_en,
    output logic hs_term_en,
    output logic hs_tx_en,
    output logic chirp_k_drive
);
    initial begin
        if (WAKE_CYC < 1 || CLK_DIV < 1 || CLK_DIV > 255) begin
            $error("hsc_phy_end: bad parameter");
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic [1:0] line_s1_q;
    logic [1:0] line_s2_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_s1_q <= `HSC_LINE_SE0;
            line_s2_q <= `HSC_LINE_SE0;
        end else begin
            line_s1_q <= {dm_in, dp_in};
            line_s2_q <= line_s1_q;
        end
    end
    // raw line state, no duration filter here
    assign lnk.bus_line_condition = line_s2_q;

    ////////////////////////////////////////////////////////////////////
    // output clock stays quiet until the oscillator is usable
    logic [31:0] wake_q;
    logic run_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wake_q <= 32'h0000_0000;
            run_q <= 1'b1;
        end else if (!lnk.low_power_request_n) begin
            wake_q <= 32'h0000_0000;
            run_q <= 1'b0;
        end else if (!run_q) begin
            if (wake_q >= 32'(WAKE_CYC - 1)) begin
                run_q <= 1'b1;
            end
            wake_q <= wake_q + 32'h0000_0001;
        end
    end

    logic [7:0] div_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 8'h00;
        end else if (!run_q || div_q == 8'(CLK_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign lnk.phy_clk_en = run_q && div_q == 8'(CLK_DIV - 1);

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dp_pullup_en <= 1'b0;
            hs_term_en <= 1'b0;
            hs_tx_en <= 1'b0;
            chirp_k_drive <= 1'b0;
        end else begin
            dp_pullup_en <= lnk.termination_select == `HSC_TERM_FS;
            hs_term_en <= lnk.termination_select == `HSC_TERM_HS;
            hs_tx_en <= lnk.speed_select == `HSC_SPEED_HS && lnk.tx_valid;
            // all-zero raw data is a continuous K
            chirp_k_drive <= lnk.speed_select == `HSC_SPEED_HS
                && lnk.tx_valid
                && lnk.operational_select == `HSC_OPSEL_RAW
                && lnk.tx_data == `HSC_TX_ZERO;
        end
    end
endmodule // hsc_phy_end
`default_nettype wire

// File: design/hsc_link_end.sv
// hsc_link_end: link end of the high-speed chirp handshake
// assumes: transceiver end on the same sys_clk; bus reset detection and
// suspend decision come from neighbouring link logic
//
// Contract
// - chirp uses raw mode, high speed, zero data
// - chirp at least 1 ms, ends by 7 ms
// - chirp held 66000 output clock cycles
// - chirp starts soon after handshake begins
// - high-speed termination only after six chirps
// - switch to high speed within 500 us
// - no chirps: fall back to full speed
// - line condition steps validation, chirp tally kept
// - chirp valid after 165 steady cycles
// - transceiver reports the line unfiltered
// - upstream chirp starts within 100 us
// - upstream chirp states last 40-60 us
// - upstream stops chirps before reset ends
// - reset lasts at least 10 ms
// - handshake may start 4 ms late
// - J to SE0 in suspend wakes combinatorially
// - no output clock until usable
// - first output clock within 5.6 ms
// - from suspend, chirp after first clock edge
// - output clock nominal within 20 ms
// - raw mode is operational select 10
`timescale 1ns/100ps
`default_nettype none
`include "hsc_consts.svh"
module hsc_link_end
    import hsc_pkg::*;
#(
    parameter int CHIRP_CYC = `HSC_CHIRP_CYC,
    parameter int FILT_CYC = `HSC_FILT_CYC,
    parameter int FS_TIMEOUT_CYC = `HSC_FS_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // transceiver side
    hsc_if.link phy,
    // user side
    input wire logic bus_reset_seen,
    input wire logic suspend_req,
    output logic handshake_busy,
    output logic hs_mode,
    output logic fs_fallback,
    output logic [2:0] chirp_tally
);
    initial begin
        if (CHIRP_CYC < 1 || CHIRP_CYC > 131071 || FS_TIMEOUT_CYC < 1
            || FS_TIMEOUT_CYC > 131071 || FILT_CYC < 2
            || FILT_CYC > 255) begin
            $error("hsc_link_end: bad parameter");
        end
    end

    ////////////////////////////////////////////////////////////////////
    hsc_state_t state_q;
    hsc_state_t state_d;
    logic [16:0] cnt_q;
    logic [7:0] filt_q;
    logic [1:0] line_q;
    logic [2:0] tally_q;
    logic prev_j_q;
    logic chirp_done;
    logic listen_timeout;
    logic chirp_hit;
    logic hit_expected;
    logic wake_evt;
    logic [1:0] expect_line;

    ////////////////////////////////////////////////////////////////////
    // suspend wake: a J followed by SE0 drops the request at once,
    // the output clock is not running so a clocked path would stall
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prev_j_q <= 1'b0;
        end else begin
            prev_j_q <= phy.bus_line_condition == `HSC_LINE_J;
        end
    end
    assign wake_evt = state_q == HSC_ST_SUSP && prev_j_q
        && phy.bus_line_condition == `HSC_LINE_SE0;
    assign phy.low_power_request_n = state_q != HSC_ST_SUSP
        || wake_evt;

    ////////////////////////////////////////////////////////////////////
    // line sampled on every output clock edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_q <= `HSC_LINE_SE0;
        end else if (phy.phy_clk_en) begin
            line_q <= phy.bus_line_condition;
        end
    end

    // duration filter; restarts on any change of line condition
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            filt_q <= 8'h00;
        end else if (state_q != HSC_ST_LISTEN) begin
            filt_q <= 8'h00;
        end else if (phy.phy_clk_en) begin
            if (phy.bus_line_condition != line_q) begin
                filt_q <= 8'h00;
            end else if (filt_q != 8'(FILT_CYC - 1)) begin
                filt_q <= filt_q + 8'h01;
            end
        end
    end
    // one pulse when a state has stood for the full filter time
    assign chirp_hit = state_q == HSC_ST_LISTEN && phy.phy_clk_en
        && phy.bus_line_condition == line_q
        && filt_q == 8'(FILT_CYC - 2);

    ////////////////////////////////////////////////////////////////////
    // chirp tally: expects K first, then alternating J and K
    assign expect_line = tally_q[0] ? `HSC_LINE_J : `HSC_LINE_K;
    assign hit_expected = chirp_hit && line_q == expect_line;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tally_q <= 3'h0;
        end else if (state_q != HSC_ST_LISTEN) begin
            tally_q <= 3'h0;
        end else if (hit_expected) begin
            tally_q <= tally_q + 3'h1;
        end else if (chirp_hit && line_q == `HSC_LINE_K) begin
            // out of order K restarts the sequence on itself
            tally_q <= 3'h1;
        end else if (chirp_hit) begin
            tally_q <= 3'h0;
        end
    end
    assign chirp_tally = tally_q;

    ////////////////////////////////////////////////////////////////////
    // one counter shared by chirp length and listen timeout,
    // counted in output clock cycles so a fast clock still gives 1 ms
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 17'h0_0000;
        end else if (state_q != state_d) begin
            cnt_q <= 17'h0_0000;
        end else if (phy.phy_clk_en) begin
            cnt_q <= cnt_q + 17'h0_0001;
        end
    end
    assign chirp_done = phy.phy_clk_en
        && cnt_q == 17'(CHIRP_CYC - 1);
    assign listen_timeout = phy.phy_clk_en
        && cnt_q == 17'(FS_TIMEOUT_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            HSC_ST_IDLE, HSC_ST_HS, HSC_ST_FS: begin
                if (suspend_req) begin
                    state_d = HSC_ST_SUSP;
                end else if (bus_reset_seen) begin
                    // timing runs from handshake start, late starts fit
                    state_d = HSC_ST_CHIRP;
                end
            end
            HSC_ST_SUSP: begin
                if (wake_evt) begin
                    state_d = HSC_ST_WAKE;
                end else if (!suspend_req) begin
                    state_d = HSC_ST_IDLE;
                end
            end
            HSC_ST_WAKE: begin
                // first clock edge after wake starts the chirp
                if (phy.phy_clk_en) begin
                    state_d = HSC_ST_CHIRP;
                end
            end
            HSC_ST_CHIRP: begin
                if (chirp_done) begin
                    state_d = HSC_ST_LISTEN;
                end
            end
            HSC_ST_LISTEN: begin
                if (hit_expected
                    && tally_q == 3'(`HSC_CHIRP_PAIRS - 1)) begin
                    state_d = HSC_ST_HS;
                end else if (listen_timeout) begin
                    state_d = HSC_ST_FS;
                end
            end
            default: begin
                state_d = HSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= HSC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transceiver controls follow the next state, no extra latency
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phy.operational_select <= `HSC_OPSEL_NORMAL;
            phy.speed_select <= `HSC_SPEED_FS;
            phy.termination_select <= `HSC_TERM_FS;
            phy.tx_valid <= 1'b0;
        end else begin
            unique case (state_d)
                HSC_ST_CHIRP: begin
                    phy.operational_select <= `HSC_OPSEL_RAW;
                    phy.speed_select <= `HSC_SPEED_HS;
                    phy.termination_select <= `HSC_TERM_FS;
                    phy.tx_valid <= 1'b1;
                end
                HSC_ST_LISTEN: begin
                    // keep high-speed receiver on to watch the line
                    phy.operational_select <= `HSC_OPSEL_RAW;
                    phy.speed_select <= `HSC_SPEED_HS;
                    phy.termination_select <= `HSC_TERM_FS;
                    phy.tx_valid <= 1'b0;
                end
                HSC_ST_HS: begin
                    // pull-up off, hs terms on, then wait for reset end
                    phy.operational_select <= `HSC_OPSEL_NORMAL;
                    phy.speed_select <= `HSC_SPEED_HS;
                    phy.termination_select <= `HSC_TERM_HS;
                    phy.tx_valid <= 1'b0;
                end
                default: begin
                    // also covers the no-chirp fallback
                    phy.operational_select <= `HSC_OPSEL_NORMAL;
                    phy.speed_select <= `HSC_SPEED_FS;
                    phy.termination_select <= `HSC_TERM_FS;
                    phy.tx_valid <= 1'b0;
                end
            endcase
        end
    end
    // upstream chirp timing and stop point are its own business;
    // the filter above only needs each state to last 165 output clock cycles, 2.75 us at 60 MHz
    assign phy.tx_data = `HSC_TX_ZERO;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            handshake_busy <= 1'b0;
            hs_mode <= 1'b0;
            fs_fallback <= 1'b0;
        end else begin
            handshake_busy <= state_d == HSC_ST_CHIRP
                || state_d == HSC_ST_LISTEN || state_d == HSC_ST_WAKE;
            hs_mode <= state_d == HSC_ST_HS;
            fs_fallback <= state_d == HSC_ST_FS;
        end
    end
endmodule // hsc_link_end
`default_nettype wire

// File: testbench/hsc_chirp_properties.sv
// hsc_chirp_properties: assertions on the link to transceiver interface
// assumes: instantiated in the bench beside the interface; one clock
`timescale 1ns/100ps
`default_nettype none
`include "hsc_consts.svh"
module hsc_chirp_properties
    import hsc_pkg::*;
#(
    parameter int CHIRP_CYC = 50,
    parameter int FILT_CYC = 5,
    parameter int FS_TIMEOUT_CYC = 300,
    parameter int WAKE_CYC = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // interface signals
    input wire logic [1:0] bus_line_condition,
    input wire logic phy_clk_en,
    input wire logic low_power_request_n,
    input wire logic [1:0] operational_select,
    input wire logic speed_select,
    input wire logic termination_select,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid
);
    localparam int WAKE_MAX = WAKE_CYC + 4;
    int chirp_q;
    int listen_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    // pulse counters: chirp length and time spent listening
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) chirp_q <= 0;
        else if (!tx_valid) chirp_q <= 0;
        else if (phy_clk_en) chirp_q <= chirp_q + 1;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) listen_q <= 0;
        else if (tx_valid || !speed_select || !termination_select) listen_q <= 0;
        else if (phy_clk_en) listen_q <= listen_q + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_chirp_on;
        tx_valid && operational_select == `HSC_OPSEL_RAW &&
            speed_select == `HSC_SPEED_HS && tx_data == `HSC_TX_ZERO;
    endsequence
    sequence s_hs_set;
        termination_select == `HSC_TERM_HS && speed_select == `HSC_SPEED_HS &&
            operational_select == `HSC_OPSEL_NORMAL;
    endsequence
    AST_CHIRP_MODE: assert property (tx_valid |-> s_chirp_on)
        else $error("chirp sent outside raw high speed zero data");
    AST_CHIRP_START: assert property ($rose(speed_select) |-> s_chirp_on)
        else $error("high speed selected without chirp");
    AST_CHIRP_LEN: assert property ($fell(tx_valid) |->
        chirp_q >= CHIRP_CYC && chirp_q <= CHIRP_CYC + 1)
        else $error("chirp length wrong");
    AST_TERM_AFTER_CHIRPS: assert property ($fell(termination_select) |->
        $past(operational_select) == `HSC_OPSEL_RAW &&
        $past(bus_line_condition) == `HSC_LINE_J &&
        $past(bus_line_condition, FILT_CYC) == `HSC_LINE_J)
        else $error("high speed terms without filtered last chirp");
    AST_HS_SWITCH: assert property ($fell(termination_select) |-> (s_hs_set) [*3])
        else $error("high speed state not entered");
    AST_FS_TIMEOUT: assert property ($fell(speed_select) |->
        termination_select == `HSC_TERM_FS &&
        listen_q >= FS_TIMEOUT_CYC - 1 && listen_q <= FS_TIMEOUT_CYC + 1)
        else $error("full speed fallback at wrong time");
    AST_LPRN_WAKE: assert property (bus_line_condition == `HSC_LINE_SE0 &&
        $past(bus_line_condition) == `HSC_LINE_J &&
        !$past(low_power_request_n) |-> low_power_request_n)
        else $error("low power not released on reset");
    AST_NO_CLK_LP: assert property (!low_power_request_n &&
        !$past(low_power_request_n) |-> !phy_clk_en)
        else $error("output clock while in low power");
    AST_WAKE_CLK: assert property ($rose(low_power_request_n) |->
        ##[1:WAKE_MAX] phy_clk_en)
        else $error("output clock late after wake");
    AST_WAKE_QUIET: assert property ($rose(low_power_request_n) |->
        (!tx_valid) [*8])
        else $error("chirp before output clock usable");
endmodule // hsc_chirp_properties
`default_nettype wire

// File: testbench/hs_chirp_handshake_tb.sv
// hs_chirp_handshake_tb: both ends joined by hsc_if, link user side and pins
// assumes: shortened counts; pins driven as {dm,dp} line states
`timescale 1ns/100ps
`default_nettype none
`include "hsc_consts.svh"
module hs_chirp_handshake_tb
    import hsc_pkg::*;
;
    localparam int CHIRP = 50;
    localparam int FILT = 5;
    localparam int FST = 300;
    localparam int WAKE = 20;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic bus_reset_seen = 1'b0;
    logic suspend_req = 1'b0;
    logic dp_in = 1'b0;
    logic dm_in = 1'b0;
    logic handshake_busy, hs_mode, fs_fallback;
    logic [2:0] chirp_tally;
    logic dp_pullup_en, hs_term_en, hs_tx_en, chirp_k_drive;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n;
    hsc_if i_hsc_if ();
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    hsc_link_end #(.CHIRP_CYC(CHIRP), .FILT_CYC(FILT), .FS_TIMEOUT_CYC(FST))
    i_hsc_link_end (.sys_clk(sys_clk), .rstn(rstn), .phy(i_hsc_if),
        .bus_reset_seen(bus_reset_seen), .suspend_req(suspend_req),
        .handshake_busy(handshake_busy), .hs_mode(hs_mode),
        .fs_fallback(fs_fallback), .chirp_tally(chirp_tally));
    hsc_phy_end #(.WAKE_CYC(WAKE), .CLK_DIV(1)) i_hsc_phy_end (
        .sys_clk(sys_clk), .rstn(rstn), .lnk(i_hsc_if), .dp_in(dp_in),
        .dm_in(dm_in), .dp_pullup_en(dp_pullup_en), .hs_term_en(hs_term_en),
        .hs_tx_en(hs_tx_en), .chirp_k_drive(chirp_k_drive));
    hsc_chirp_properties #(.CHIRP_CYC(CHIRP), .FILT_CYC(FILT),
        .FS_TIMEOUT_CYC(FST), .WAKE_CYC(WAKE)) i_hsc_chirp_properties (
        .sys_clk(sys_clk), .rstn(rstn),
        .bus_line_condition(i_hsc_if.bus_line_condition),
        .phy_clk_en(i_hsc_if.phy_clk_en),
        .low_power_request_n(i_hsc_if.low_power_request_n),
        .operational_select(i_hsc_if.operational_select),
        .speed_select(i_hsc_if.speed_select),
        .termination_select(i_hsc_if.termination_select),
        .tx_data(i_hsc_if.tx_data), .tx_valid(i_hsc_if.tx_valid));
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic check_rng(input string what, input int lo, input int hi,
        input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
                hi, got);
            n_mismatch++;
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic hit(input int which);
        case (which)
            0: return i_hsc_if.tx_valid === 1'b0;
            1: return hs_mode === 1'b1;
            2: return fs_fallback === 1'b1;
            3: return i_hsc_if.bus_line_condition === `HSC_LINE_SE0;
            default: return i_hsc_if.tx_valid === 1'b1;
        endcase
    endfunction
    // every wait is bounded; a wait that runs out closes the run
    task automatic wait_for(input int which, input int bound, output int k);
        k = 0;
        while (!hit(which) && k < bound) begin
            tick(1);
            k++;
        end
        if (k >= bound) begin
            $display("CHECK FAILED wait %0d expected hit seen none", which);
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic line_st(input logic [1:0] st, input int k);
        @(posedge sys_clk);
        {dm_in, dp_in} <= st;
        repeat (k - 1) @(posedge sys_clk);
    endtask
    task automatic pulse_req();
        @(posedge sys_clk);
        bus_reset_seen <= 1'b1;
        @(posedge sys_clk);
        bus_reset_seen <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        tick(2);
        check("opsel", `HSC_OPSEL_NORMAL, i_hsc_if.operational_select);
        check("speed", `HSC_SPEED_FS, i_hsc_if.speed_select);
        check("term", `HSC_TERM_FS, i_hsc_if.termination_select);
        check("lprn", 1'b1, i_hsc_if.low_power_request_n);
        check("pullup", 1'b1, dp_pullup_en);
        $display("test reset done");
        // high speed handshake, glitch first
        pulse_req();
        check("opsel", `HSC_OPSEL_RAW, i_hsc_if.operational_select);
        check("speed", `HSC_SPEED_HS, i_hsc_if.speed_select);
        check("txvalid", 1'b1, i_hsc_if.tx_valid);
        check("txdata", `HSC_TX_ZERO, i_hsc_if.tx_data);
        check("busy", 1'b1, handshake_busy);
        tick(2);
        check("kdrive", 1'b1, chirp_k_drive);
        check("hstx", 1'b1, hs_tx_en);
        wait_for(0, CHIRP + 5, n);
        check_rng("chirp len", CHIRP, CHIRP + 1, n + 2);
        // a short K must not count, the filter restarts
        line_st(`HSC_LINE_K, FILT - 3);
        line_st(`HSC_LINE_SE0, 6);
        tick(0);
        check("tally glitch", 3'h0, chirp_tally);
        check("hstx off", 1'b0, hs_tx_en);
        for (int i = 0; i < 5; i++) begin
            line_st(i[0] ? `HSC_LINE_J : `HSC_LINE_K, 10);
        end
        tick(0);
        check("tally", 3'h5, chirp_tally);
        check("term early", `HSC_TERM_FS, i_hsc_if.termination_select);
        line_st(`HSC_LINE_J, FILT + 4);
        wait_for(1, 10, n);
        check("term", `HSC_TERM_HS, i_hsc_if.termination_select);
        check("opsel", `HSC_OPSEL_NORMAL, i_hsc_if.operational_select);
        tick(1);
        check("hsterm", 1'b1, hs_term_en);
        check("pullup", 1'b0, dp_pullup_en);
        check("busy", 1'b0, handshake_busy);
        line_st(`HSC_LINE_SE0, 2);
        $display("test hs handshake done");
        // back to back request, no upstream chirps
        pulse_req();
        check("txvalid", 1'b1, i_hsc_if.tx_valid);
        wait_for(0, CHIRP + 5, n);
        wait_for(2, FST + 20, n);
        check_rng("fallback", FST - 1, FST + 2, n);
        check("speed", `HSC_SPEED_FS, i_hsc_if.speed_select);
        check("hsmode", 1'b0, hs_mode);
        $display("test fs fallback done");
        // reset from low power
        @(posedge sys_clk);
        suspend_req <= 1'b1;
        tick(2);
        check("lprn", 1'b0, i_hsc_if.low_power_request_n);
        tick(WAKE + 5);
        check("clk quiet", 1'b0, i_hsc_if.phy_clk_en);
        line_st(`HSC_LINE_J, 4);
        line_st(`HSC_LINE_SE0, 1);
        wait_for(3, 6, n);
        check("lprn wake", 1'b1, i_hsc_if.low_power_request_n);
        @(posedge sys_clk);
        suspend_req <= 1'b0;
        wait_for(4, WAKE + 10, n);
        check_rng("wake", WAKE - 2, WAKE + 4, n);
        wait_for(0, CHIRP + 5, n);
        check_rng("wake chirp", CHIRP - 1, CHIRP + 1, n);
        // out of order K restarts the tally, a bad line state clears it
        line_st(`HSC_LINE_K, 10);
        line_st(`HSC_LINE_SE1, 2);
        line_st(`HSC_LINE_K, 10);
        tick(0);
        check("tally reorder", 3'h1, chirp_tally);
        line_st(`HSC_LINE_SE1, 10);
        tick(0);
        check("tally clear", 3'h0, chirp_tally);
        wait_for(2, FST + 20, n);
        check("speed", `HSC_SPEED_FS, i_hsc_if.speed_select);
        $display("test suspend reset done");
        complete_run();
    end
endmodule // hs_chirp_handshake_tb
`default_nettype wire
